// *** seep_top.v ***
// two-wire serial eeprom slave, write side: address decode, byte and page
// write into a page store, write protect, busy during the write cycle.
// assumes scl/sda/pins are asynchronous to mclk; the array sits outside and
// takes committed bytes over a valid/ready port that may stall.
`timescale 1ns/1ps
`default_nettype none
`include "seep_regs.vh"

module seep_top #(
   parameter DENSITY  = `SEEP_DEN_2K,
   parameter WR_CYC   = `SEEP_T_WR_MS * `SEEP_US_PER_MS * `SEEP_CLK_MHZ,
   parameter WR_CNT_W = 20,
   parameter BUF_AW   = 1
)(
   input  wire                     mclk,
   input  wire                     rst,
   input  wire                     scl_in,
   input  wire                     sda_in,
   output wire                     sda_out,
   output wire                     sda_oe,
   input  wire                     addr_select_pin_0,
   input  wire                     addr_select_pin_1,
   input  wire                     addr_select_pin_2,
   input  wire                     wp_in,
   output wire                     wr_valid,
   input  wire                     wr_ready,
   output wire [`SEEP_MADDR_W-1:0] wr_addr,
   output wire [7:0]               wr_data,
   output wire                     busy
);

   ////////////////////////////////////////////////////////////////////////
   // constants

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DEV  = 3'h1;
   localparam [2:0] ST_WORD = 3'h2;
   localparam [2:0] ST_DATA = 3'h3;
   localparam [2:0] ST_IGN  = 3'h4;

   localparam [1:0] CM_IDLE = 2'h0;
   localparam [1:0] CM_RD   = 2'h1;
   localparam [1:0] CM_PUSH = 2'h2;
   localparam [1:0] CM_WAIT = 2'h3;

   localparam [2:0] SELM = (DENSITY == `SEEP_DEN_2K) ? `SEEP_SELM_2K :
                           (DENSITY == `SEEP_DEN_4K) ? `SEEP_SELM_4K :
                           (DENSITY == `SEEP_DEN_8K) ? `SEEP_SELM_8K : `SEEP_SELM_16K;
   localparam [7:0] PMASK = (DENSITY == `SEEP_DEN_2K) ? `SEEP_PMASK_2K : `SEEP_PMASK_BIG;
   localparam [`SEEP_PG_AW-1:0] PG_LAST = PMASK[`SEEP_PG_AW-1:0];
   localparam [31:0]            WR_LAST_W = WR_CYC - 1;
   localparam [WR_CNT_W-1:0]    WR_LAST = WR_LAST_W[WR_CNT_W-1:0];
   localparam BW = `SEEP_MADDR_W + 8;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [`SEEP_SYNC_N-1:0] pin_raw;
   wire [`SEEP_SYNC_N-1:0] sy2;
   wire [`SEEP_SYNC_N-1:0] sy3;

   assign pin_raw = {wp_in, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, sda_in, scl_in};

   genvar gi;
   generate
      for (gi = 0; gi < `SEEP_SYNC_N; gi = gi + 1)
      begin : g_sync
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         // first stage feeds only the second one
         always @(posedge mclk)
         begin
            if (rst)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
            end
            else
            begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         assign sy2[gi] = s2_reg;
         assign sy3[gi] = s3_reg;
      end
   endgenerate

   wire       scl   = sy2[0];
   wire       scl_d = sy3[0];
   wire       sda   = sy2[1];
   wire       sda_d = sy3[1];
   wire [2:0] pins  = sy2[4:2];    // open pins arrive as zero
   wire       wp    = sy2[5];

   wire scl_rise  = scl & ~scl_d;
   wire scl_fall  = ~scl & scl_d;
   wire start_det = scl & scl_d & sda_d & ~sda;
   wire stop_det  = scl & scl_d & ~sda_d & sda;

   ////////////////////////////////////////////////////////////////////////
   // state

   reg [2:0]                st_reg;
   reg [3:0]                bit_reg;
   reg [7:0]                shift_reg;
   reg                      ack_pend_reg;
   reg                      oe_reg;
   reg [2:0]                blk_reg;
   reg [7:0]                word_reg;
   reg [(1<<`SEEP_PG_AW)-1:0] mask_reg;
   reg [1:0]                cm_reg;
   reg [`SEEP_PG_AW-1:0]    idx_reg;
   reg [WR_CNT_W-1:0]       wcnt_reg;

   wire       cm_busy = (cm_reg != CM_IDLE);
   wire [7:0] byte_in = {shift_reg[6:0], sda};
   wire       byte_end = scl_rise & (bit_reg == `SEEP_BIT_LAST) & (st_reg != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // address byte decode

   wire [2:0] sel_field = byte_in[`SEEP_SEL_HI:`SEEP_SEL_LO];
   wire       code_ok   = (byte_in[`SEEP_DC_HI:`SEEP_DC_LO] == `SEEP_DEV_CODE);
   wire       sel_ok    = (((sel_field ^ pins) & SELM) == 3'h0);
   wire [2:0] blk_in    = sel_field & ~SELM;
   wire       rd_dir    = byte_in[`SEEP_RW_BIT];

   // next word address: low page bits roll, upper bits stay
   wire [7:0] word_inc  = word_reg + 8'h01;
   wire [7:0] word_roll = (word_reg & ~PMASK) | (word_inc & PMASK);

   wire                   pg_we    = byte_end & (st_reg == ST_DATA) & ~wp;
   wire [`SEEP_PG_AW-1:0] pg_waddr = word_reg[`SEEP_PG_AW-1:0] & PMASK[`SEEP_PG_AW-1:0];
   wire [(1<<`SEEP_PG_AW)-1:0] pg_bit =
      {{((1<<`SEEP_PG_AW)-1){1'b0}}, 1'b1} << pg_waddr;

   wire commit_go = stop_det & (st_reg == ST_DATA) & (mask_reg != {(1<<`SEEP_PG_AW){1'b0}}) & ~cm_busy;

   ////////////////////////////////////////////////////////////////////////
   // bus protocol

   always @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg       <= ST_IDLE;
         bit_reg      <= 4'h0;
         shift_reg    <= 8'h00;
         ack_pend_reg <= 1'b0;
         oe_reg       <= 1'b0;
         blk_reg      <= 3'h0;
         word_reg     <= 8'h00;
         mask_reg     <= {(1<<`SEEP_PG_AW){1'b0}};
      end
      else if (start_det)
      begin
         // every operation opens here, also a repeated start
         st_reg       <= ST_DEV;
         bit_reg      <= 4'h0;
         ack_pend_reg <= 1'b0;
         oe_reg       <= 1'b0;
      end
      else if (stop_det)
      begin
         // page store handed to the commit side by commit_go
         st_reg       <= ST_IDLE;
         bit_reg      <= 4'h0;
         ack_pend_reg <= 1'b0;
         oe_reg       <= 1'b0;
      end
      else
      begin
         if (scl_rise & (st_reg != ST_IDLE))
         begin
            shift_reg <= byte_in;
            if (bit_reg == `SEEP_BIT_ACK)
            begin
               bit_reg <= 4'h0;
            end
            else
            begin
               bit_reg <= bit_reg + 4'h1;
            end
         end
         // ack drives from the falling edge after bit eight to the one after clock nine
         if (scl_fall)
         begin
            if (ack_pend_reg)
            begin
               oe_reg       <= 1'b1;
               ack_pend_reg <= 1'b0;
            end
            else if (oe_reg & (bit_reg == 4'h0))
            begin
               oe_reg <= 1'b0;
            end
         end
         if (byte_end)
         begin
            case (st_reg)
               ST_DEV:
               begin
                  if (code_ok & sel_ok & ~cm_busy)
                  begin
                     ack_pend_reg <= 1'b1;
                     // read side is not built: after the poll ack the bus is let go
                     if (rd_dir)
                     begin
                        st_reg <= ST_IGN;
                     end
                     else
                     begin
                        st_reg   <= ST_WORD;
                        blk_reg  <= blk_in;
                        mask_reg <= {(1<<`SEEP_PG_AW){1'b0}};
                     end
                  end
                  else
                  begin
                     st_reg <= ST_IGN;
                  end
               end
               ST_WORD:
               begin
                  ack_pend_reg <= 1'b1;
                  word_reg     <= byte_in;
                  st_reg       <= ST_DATA;
               end
               ST_DATA:
               begin
                  if (~wp)
                  begin
                     ack_pend_reg <= 1'b1;
                     mask_reg     <= mask_reg | pg_bit;
                     word_reg     <= word_roll;
                  end
                  // protected: byte dropped, no ack
               end
               ST_IGN:
               begin
                  st_reg <= ST_IGN;
               end
               default:
               begin
                  st_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write cycle: drain the page store, then hold busy for the write time

   wire                   pg_re    = (cm_reg == CM_RD);
   wire [7:0]             pg_rdata;
   wire                   buf_in_ready;
   wire                   slot_hit = mask_reg[idx_reg];
   wire                   buf_in_valid = (cm_reg == CM_PUSH) & slot_hit;
   wire                   advance  = (cm_reg == CM_PUSH) & (~slot_hit | buf_in_ready);
   wire [7:0]             pg_addr  = (word_reg & ~PMASK) | {{(8-`SEEP_PG_AW){1'b0}}, idx_reg};
   wire [BW-1:0]          buf_in_data = {blk_reg, pg_addr, pg_rdata};
   wire [BW-1:0]          buf_out_data;

   always @(posedge mclk)
   begin
      if (rst)
      begin
         cm_reg   <= CM_IDLE;
         idx_reg  <= {`SEEP_PG_AW{1'b0}};
         wcnt_reg <= {WR_CNT_W{1'b0}};
      end
      else
      begin
         case (cm_reg)
            CM_IDLE:
            begin
               if (commit_go)
               begin
                  cm_reg  <= CM_RD;
                  idx_reg <= {`SEEP_PG_AW{1'b0}};
               end
            end
            CM_RD:
            begin
               cm_reg <= CM_PUSH;
            end
            CM_PUSH:
            begin
               // a stalled array holds us here and stretches busy
               if (advance)
               begin
                  if (idx_reg == PG_LAST)
                  begin
                     cm_reg   <= CM_WAIT;
                     wcnt_reg <= {WR_CNT_W{1'b0}};
                  end
                  else
                  begin
                     idx_reg <= idx_reg + {{(`SEEP_PG_AW-1){1'b0}}, 1'b1};
                     cm_reg  <= CM_RD;
                  end
               end
            end
            CM_WAIT:
            begin
               if (wcnt_reg == WR_LAST)
               begin
                  cm_reg <= CM_IDLE;
               end
               else
               begin
                  wcnt_reg <= wcnt_reg + {{(WR_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            default:
            begin
               cm_reg <= CM_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page store and output buffer

   seep_mem #(
      .DW (8),
      .AW (`SEEP_PG_AW)
   ) u_page (
      .clk   (mclk),
      .we    (pg_we),
      .waddr (pg_waddr),
      .wdata (byte_in),
      .re    (pg_re),
      .raddr (idx_reg),
      .rdata (pg_rdata)
   );

   seep_buf #(
      .W  (BW),
      .AW (BUF_AW)
   ) u_buf (
      .clk       (mclk),
      .rst       (rst),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;
   assign wr_addr = buf_out_data[BW-1:8];
   assign wr_data = buf_out_data[7:0];
   assign busy    = cm_busy;

endmodule // seep_top

`default_nettype wire

// *** seep_regs.vh ***
// constants for the two-wire eeprom write path: address byte layout,
// variant codes, page masks, bit counts and write cycle time.
// assumes it is included by every file that uses its macros.
`ifndef SEEP_REGS_VH
`define SEEP_REGS_VH

// address byte layout
`define SEEP_DEV_CODE   4'ha
`define SEEP_DC_HI      7
`define SEEP_DC_LO      4
`define SEEP_SEL_HI     3
`define SEEP_SEL_LO     1
`define SEEP_RW_BIT     0

// variant codes for the DENSITY parameter
`define SEEP_DEN_2K     0
`define SEEP_DEN_4K     1
`define SEEP_DEN_8K     2
`define SEEP_DEN_16K    3

// which of the three select bits are compared with pins (rest are block bits)
`define SEEP_SELM_2K    3'h7
`define SEEP_SELM_4K    3'h6
`define SEEP_SELM_8K    3'h4
`define SEEP_SELM_16K   3'h0

// low word-address bits that roll inside a page
`define SEEP_PMASK_2K   8'h07
`define SEEP_PMASK_BIG  8'h0f
`define SEEP_PG_AW      4

// bit counter values
`define SEEP_BIT_LAST   4'h7
`define SEEP_BIT_ACK    4'h8

// memory address width: three block bits and eight word bits
`define SEEP_MADDR_W    11

// write cycle time
`define SEEP_T_WR_MS    5
`define SEEP_US_PER_MS  1000
`define SEEP_CLK_MHZ    100

// number of synchronised pins
`define SEEP_SYNC_N     6

`endif

// *** seep_mem.v ***
// small page store: one write port, one read port with registered data.
// assumes a single clock; read data hold until the next read enable.
`timescale 1ns/1ps
`default_nettype none

module seep_mem #(
   parameter DW = 8,
   parameter AW = 4
)(
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire          re,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);

   reg [DW-1:0] mem_reg [0:(1<<AW)-1];

   always @(posedge clk)
   begin
      if (we)
      begin
         mem_reg[waddr] <= wdata;
      end
      if (re)
      begin
         rdata <= mem_reg[raddr];
      end
   end

endmodule // seep_mem

`default_nettype wire

// *** seep_buf.v ***
// small valid/ready buffer, 2**AW entries, first in first out.
// assumes both sides on one clock; synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none

module seep_buf #(
   parameter W  = 19,
   parameter AW = 1
)(
   input  wire         clk,
   input  wire         rst,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);

   localparam DEPTH = 1 << AW;

   reg [W-1:0]  slot_reg [0:DEPTH-1];
   reg [AW-1:0] wptr_reg;
   reg [AW-1:0] rptr_reg;
   reg [AW:0]   cnt_reg;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   // full and empty come straight from the occupancy count
   assign in_ready  = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data  = slot_reg[rptr_reg];

   always @(posedge clk)
   begin
      if (push)
      begin
         slot_reg[wptr_reg] <= in_data;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         wptr_reg <= {AW{1'b0}};
         rptr_reg <= {AW{1'b0}};
         cnt_reg  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop)
         begin
            cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
         end
         else if (pop & ~push)
         begin
            cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // seep_buf

`default_nettype wire

// *** seep_top_properties.sv ***
// checker: ack timing, busy window and write port of the eeprom slave.
// assumes it is bound to every seep_top instance.
`timescale 1ns/1ps
`default_nettype none
`include "seep_regs.vh"

module seep_top_properties #(
   parameter DENSITY  = `SEEP_DEN_2K,
   parameter WR_CYC   = 50,
   parameter WR_CNT_W = 20,
   parameter BUF_AW   = 1
)(
   input wire logic                     mclk,
   input wire logic                     rst,
   input wire logic                     scl_in,
   input wire logic                     sda_in,
   input wire logic                     sda_out,
   input wire logic                     sda_oe,
   input wire logic                     addr_select_pin_0,
   input wire logic                     addr_select_pin_1,
   input wire logic                     addr_select_pin_2,
   input wire logic                     wp_in,
   input wire logic                     wr_valid,
   input wire logic                     wr_ready,
   input wire logic [`SEEP_MADDR_W-1:0] wr_addr,
   input wire logic [7:0]               wr_data,
   input wire logic                     busy
);
   localparam int PW = (DENSITY == `SEEP_DEN_2K) ? 3 : 4;
   logic [10:0] last_reg;
   logic        seen_reg;
   ////////////////////////////////////////////////////////////
   // last accepted word; forgotten once the write cycle ends
   always @(posedge mclk)
   begin
      if (rst || !busy)
         seen_reg <= 1'h0;
      else if (wr_valid && wr_ready)
         seen_reg <= 1'h1;
      if (wr_valid && wr_ready)
         last_reg <= wr_addr;
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_ack_edge; $changed(sda_oe) |-> !scl_in; endproperty
   property p_ack_stands; sda_oe && scl_in |=> sda_oe; endproperty
   property p_busy_nack; busy |-> !sda_oe; endproperty
   property p_busy_hold; $rose(busy) |=> busy [*8]; endproperty
   property p_push_busy; wr_valid |-> busy; endproperty
   property p_stall; wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data); endproperty
   property p_block; wr_valid |-> (wr_addr[10:8] >> DENSITY) == 3'h0; endproperty
   // page entries leave in ascending order and never leave their page
   property p_page_up; wr_valid && seen_reg |-> wr_addr > last_reg && (wr_addr >> PW) == (last_reg >> PW); endproperty
   a_ack_edge: assert property (p_ack_edge) else $error("ack moved while scl high");
   a_ack_stands: assert property (p_ack_stands) else $error("ack dropped in clock high");
   a_busy_nack: assert property (p_busy_nack) else $error("ack during write cycle");
   a_busy_hold: assert property (p_busy_hold) else $error("write cycle too short");
   a_push_busy: assert property (p_push_busy) else $error("word outside write cycle");
   a_stall: assert property (p_stall) else $error("word lost under stall");
   a_block: assert property (p_block) else $error("block bits out of range");
   a_page_up: assert property (p_page_up) else $error("page order or page bits wrong");
   c_write: cover property ($rose(busy));
   c_stall: cover property (wr_valid && !wr_ready);
   c_ack: cover property ($rose(sda_oe));
endmodule // seep_top_properties

bind seep_top seep_top_properties #(.DENSITY(DENSITY), .WR_CYC(WR_CYC), .WR_CNT_W(WR_CNT_W), .BUF_AW(BUF_AW))
   u_seep_top_properties (.mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .addr_select_pin_0(addr_select_pin_0), .addr_select_pin_1(addr_select_pin_1),
   .addr_select_pin_2(addr_select_pin_2), .wp_in(wp_in), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));

`default_nettype wire

// *** seep_master.sv ***
// bus master model: start, stop and byte transfers on the two-wire link.
// assumes a pull-up outside resolves sda from every party's pull.
`timescale 1ns/1ps
`default_nettype none

module seep_master (
   output var logic scl,
   output var logic pull,
   input  wire logic sda
);
   // scl stands high between frames; 80 ns bits, low 50 and high 30
   initial
   begin
      scl = 1'h1;
      pull = 1'h0;
   end
   ////////////////////////////////////////////////////////////
   // long lead-in lets a slave drop its ack before sda rises
   task automatic start_cond();
      #40 pull = 1'h0;
      #40 scl = 1'h1;
      #40 pull = 1'h1;
      #40 scl = 1'h0;
   endtask
   task automatic put_byte(input logic [7:0] b, output logic acked);
      for (int i = 7; i >= 0; i--)
      begin
         #20 pull = ~b[i];
         #30 scl = 1'h1;
         #30 scl = 1'h0;
      end
      #20 pull = 1'h0;
      #30 scl = 1'h1;
      #20 acked = ~sda;
      #10 scl = 1'h0;
   endtask
   task automatic stop_cond();
      #20 pull = 1'h1;
      #30 scl = 1'h1;
      #40 pull = 1'h0;
      #40;
   endtask
endmodule // seep_master

`default_nettype wire

// *** seep_top_tb.sv ***
// bench: a 2k, a 4k and an 8k slave share one bus driven by the master model.
// assumes the bench stands in for the array behind each write port.
`timescale 1ns/1ps
`default_nettype none
`include "seep_regs.vh"

module seep_top_tb;
   // short write time, still longer than one poll frame
   localparam WR_CYC = 500;
   logic                    mclk, rst, wp, rdy_a, rdy_b, scl, m_pull;
   logic [2:0]              pins_a, pins_b, pins_c;
   wire                     oe_a, oe_b, oe_c, val_a, val_b, val_c, busy_a, busy_b, busy_c;
   wire                     so_a, so_b, so_c;
   wire [`SEEP_MADDR_W-1:0] addr_a, addr_b, addr_c;
   wire [7:0]               data_a, data_b, data_c;
   logic [18:0]             q_a[$], q_b[$], q_c[$], exp_q[$], pg[8];
   logic [7:0]              bad[3];
   int                      err_total, n_checks;
   // a slave pulls only where its output value is low
   wire                     sda = ~(m_pull | (oe_a & ~so_a) | (oe_b & ~so_b) | (oe_c & ~so_c));
   seep_master u_seep_master (.scl(scl), .pull(m_pull), .sda(sda));
   seep_top #(.DENSITY(`SEEP_DEN_2K), .WR_CYC(WR_CYC)) u_seep_top (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(so_a), .sda_oe(oe_a),
      .addr_select_pin_0(pins_a[0]), .addr_select_pin_1(pins_a[1]), .addr_select_pin_2(pins_a[2]),
      .wp_in(wp), .wr_valid(val_a), .wr_ready(rdy_a), .wr_addr(addr_a), .wr_data(data_a), .busy(busy_a));
   seep_top #(.DENSITY(`SEEP_DEN_8K), .WR_CYC(WR_CYC)) u_seep_top_b (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(so_b), .sda_oe(oe_b),
      .addr_select_pin_0(pins_b[0]), .addr_select_pin_1(pins_b[1]), .addr_select_pin_2(pins_b[2]),
      .wp_in(wp), .wr_valid(val_b), .wr_ready(rdy_b), .wr_addr(addr_b), .wr_data(data_b), .busy(busy_b));
   seep_top #(.DENSITY(`SEEP_DEN_4K), .WR_CYC(WR_CYC)) u_seep_top_c (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(so_c), .sda_oe(oe_c),
      .addr_select_pin_0(pins_c[0]), .addr_select_pin_1(pins_c[1]), .addr_select_pin_2(pins_c[2]),
      .wp_in(wp), .wr_valid(val_c), .wr_ready(rdy_b), .wr_addr(addr_c), .wr_data(data_c), .busy(busy_c));
   initial
   begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      if (val_a && rdy_a)
         q_a.push_back({addr_a, data_a});
      if (val_b && rdy_b)
         q_b.push_back({addr_b, data_b});
      if (val_c && rdy_b)
         q_c.push_back({addr_c, data_c});
   end
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic got;
      u_seep_master.put_byte(b, got);
      check("ack", {18'h0, exp_ack}, {18'h0, got});
   endtask
   task automatic check_q(input int b);
      logic [18:0] got[$];
      if (b == 2)
         got = q_c;
      else if (b == 1)
         got = q_b;
      else
         got = q_a;
      check("word count", 19'(exp_q.size()), 19'(got.size()));
      foreach (exp_q[i])
         check("written word", exp_q[i], (i < got.size()) ? got[i] : 19'h7_ffff);
      exp_q = {};
      if (b == 2)
         q_c = {};
      else if (b == 1)
         q_b = {};
      else
         q_a = {};
   endtask
   // bounded wait for all three write cycles to end
   task automatic wait_idle();
      int n;
      n = 0;
      while ((busy_a || busy_b || busy_c) && n < 20000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20000)
      begin
         err_total++;
         $display("CHECK FAILED busy expected 0 seen 1");
         tally_and_finish();
      end
      @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      err_total = 0;
      n_checks = 0;
      bad = '{8'hba, 8'ha8, 8'h2a};
      rst = 1'h1;
      wp = 1'h0;
      rdy_a = 1'h1;
      rdy_b = 1'h1;
      pins_a = 3'h5;
      pins_b = 3'h0;
      pins_c = 3'h6;
      repeat (3) @(posedge mclk);
      @(negedge mclk) rst = 1'h0;
      repeat (6) @(negedge mclk);
      // byte write, poll while busy, poll after
      u_seep_master.start_cond();
      send(8'haa, 1'h1);
      send(8'h12, 1'h1);
      send(8'h5a, 1'h1);
      u_seep_master.stop_cond();
      u_seep_master.start_cond();
      send(8'hab, 1'h0);
      u_seep_master.stop_cond();
      wait_idle();
      u_seep_master.start_cond();
      send(8'hab, 1'h1);
      u_seep_master.stop_cond();
      exp_q.push_back({11'h012, 8'h5a});
      check_q(1'h0);
      check_q(1'h1);
      // ten bytes into an 8-byte page while the array stalls
      @(negedge mclk) rdy_a = 1'h0;
      u_seep_master.start_cond();
      send(8'haa, 1'h1);
      send(8'h3e, 1'h1);
      for (int i = 0; i < 10; i++)
      begin
         send(8'h40 + 8'(i), 1'h1);
         pg[(i + 6) % 8] = {3'h0, 8'h38 + 8'((i + 6) % 8), 8'h40 + 8'(i)};
      end
      u_seep_master.stop_cond();
      repeat (60) @(negedge mclk);
      check("stalled valid", {18'h0, val_a}, 19'h1);
      rdy_a = 1'h1;
      wait_idle();
      foreach (pg[k])
         exp_q.push_back(pg[k]);
      check_q(1'h0);
      // wrong code or select: no ack, no write
      foreach (bad[i])
      begin
         u_seep_master.start_cond();
         send(bad[i], 1'h0);
         send(8'h10, 1'h0);
         u_seep_master.stop_cond();
      end
      // protected write: data refused, nothing stored
      @(negedge mclk) wp = 1'h1;
      u_seep_master.start_cond();
      send(8'haa, 1'h1);
      send(8'h20, 1'h1);
      send(8'h77, 1'h0);
      u_seep_master.stop_cond();
      repeat (10) @(negedge mclk);
      check("busy", {18'h0, busy_a | busy_b}, 19'h0);
      wp = 1'h0;
      check_q(1'h0);
      check_q(1'h1);
      // 8k part, block 3, low nibble wraps
      u_seep_master.start_cond();
      send(8'ha6, 1'h1);
      send(8'hfe, 1'h1);
      for (int i = 0; i < 3; i++)
         send(8'h91 + 8'(i), 1'h1);
      u_seep_master.stop_cond();
      wait_idle();
      exp_q.push_back({11'h3f0, 8'h93});
      exp_q.push_back({11'h3fe, 8'h91});
      exp_q.push_back({11'h3ff, 8'h92});
      check_q(1'h1);
      check_q(1'h0);
      // 4k part, block 1, seventeen bytes: the last one lands on entry zero
      u_seep_master.start_cond();
      send(8'hae, 1'h1);
      send(8'h50, 1'h1);
      for (int i = 0; i < 17; i++)
         send(8'h60 + 8'(i), 1'h1);
      u_seep_master.stop_cond();
      wait_idle();
      exp_q.push_back({11'h150, 8'h70});
      for (int k = 1; k < 16; k++)
         exp_q.push_back({11'h150 + 11'(k), 8'h60 + 8'(k)});
      check_q(2);
      tally_and_finish();
   end
endmodule // seep_top_tb

`default_nettype wire
